// file: obl_pkg.sv
// constants, field layouts and types of the option byte loader
package obl_pkg;

	localparam int ADDR_W = 20;
	localparam int DATA_W = 8;
	localparam int NUM_BYTES = 4;
	localparam int IDX_W = 2;

	// flash locations of the option area
	localparam logic [ADDR_W-1:0] PRIMARY_BASE = 20'h000C0;
	localparam logic [ADDR_W-1:0] SWAP_BASE = 20'h010C0;
	localparam logic [IDX_W-1:0] IDX_WATCHDOG = 2'h0;
	localparam logic [IDX_W-1:0] IDX_VOLTAGE = 2'h1;
	localparam logic [IDX_W-1:0] IDX_FLASH_CLOCK = 2'h2;
	localparam logic [IDX_W-1:0] IDX_DEBUG = 2'h3;
	localparam logic [IDX_W-1:0] IDX_LAST = 2'h3;

	// register port offsets
	localparam int REG_ADDR_W = 8;
	localparam logic [REG_ADDR_W-1:0] OFS_WATCHDOG_OPTION_BYTE = 8'hC0;
	localparam logic [REG_ADDR_W-1:0] OFS_VOLTAGE_DETECT_OPTION_BYTE = 8'hC1;
	localparam logic [REG_ADDR_W-1:0] OFS_FLASH_CLOCK_OPTION_BYTE = 8'hC2;
	localparam logic [REG_ADDR_W-1:0] OFS_DEBUG_OPTION_BYTE = 8'hC3;
	localparam logic [REG_ADDR_W-1:0] OFS_LOADER_STATUS = 8'hC4;
	localparam logic [REG_ADDR_W-1:0] OFS_LOADER_CONTROL = 8'hC5;

	// status and control bits
	localparam int STAT_DONE_BIT = 0;
	localparam int STAT_SWAP_BIT = 1;
	localparam int STAT_WINDOW_ERR_BIT = 2;
	localparam int STAT_FIXED_ERR_BIT = 3;
	localparam int CTRL_RELOAD_BIT = 0;
	localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;

	// watchdog byte fields
	localparam int WD_IRQ_BIT = 7;
	localparam int WD_OPEN_HI_BIT = 6;
	localparam int WD_OPEN_LO_BIT = 5;
	localparam int WD_ENABLE_BIT = 4;
	localparam int WD_OVF_MSB = 3;
	localparam int WD_OVF_LSB = 1;
	localparam int WD_STANDBY_BIT = 0;

	// voltage detect byte fields
	localparam int VD_UPPER_MSB = 7;
	localparam int VD_UPPER_LSB = 5;
	localparam int VD_FIXED_BIT = 4;
	localparam int VD_LEVEL_MSB = 3;
	localparam int VD_LEVEL_LSB = 2;
	localparam int VD_MODE_MSB = 1;
	localparam int VD_MODE_LSB = 0;

	// flash clock byte fields
	localparam int FC_SPEED_BIT = 7;
	localparam int FC_FREQ_MSB = 1;
	localparam int FC_FREQ_LSB = 0;

	// debug byte fields
	localparam int DBG_ENABLE_BIT = 7;
	localparam int DBG_KEEP_BIT = 0;

	typedef enum logic [1:0] {
		OBL_WIN_PROHIBITED = 2'h0,
		OBL_WIN_50 = 2'h1,
		OBL_WIN_75 = 2'h2,
		OBL_WIN_100 = 2'h3
	} obl_window_t;

	typedef enum logic [1:0] {
		OBL_VD_OFF_EXT_RESET = 2'h0,
		OBL_VD_IRQ_ONLY = 2'h1,
		OBL_VD_IRQ_AND_RESET = 2'h2,
		OBL_VD_RESET_ONLY = 2'h3
	} obl_vd_mode_t;

	typedef enum logic [1:0] {
		OBL_HOCO_3MHZ = 2'h0,
		OBL_HOCO_6MHZ = 2'h1,
		OBL_HOCO_12MHZ = 2'h2,
		OBL_HOCO_24MHZ = 2'h3
	} obl_hoco_t;

endpackage

// file: obl_decode.sv
// field decoder of the four latched option bytes
`timescale 1ns/1ps
module obl_decode (
	input wire logic [obl_pkg::DATA_W-1:0] wd_byte_i,
	input wire logic [obl_pkg::DATA_W-1:0] vd_byte_i,
	input wire logic [obl_pkg::DATA_W-1:0] fc_byte_i,
	input wire logic [obl_pkg::DATA_W-1:0] dbg_byte_i,
	output logic wd_interval_irq_use_o,
	output logic wd_count_enable_o,
	output logic wd_run_in_standby_o,
	output logic [2:0] wd_overflow_sel_o,
	output obl_pkg::obl_window_t wd_window_o,
	output logic window_prohibited_o,
	output obl_pkg::obl_vd_mode_t vd_mode_o,
	output logic [2:0] detect_level_upper_o,
	output logic [1:0] detect_level_lower_o,
	output logic [4:0] detect_level_single_o,
	output logic fixed_bit_bad_o,
	output logic high_speed_main_o,
	output obl_pkg::obl_hoco_t hoco_freq_o,
	output logic on_chip_debug_enable_o,
	output logic keep_flash_on_auth_fail_o
);
	logic wd_open_period_hi;
	logic wd_open_period_lo;

	assign wd_open_period_hi = wd_byte_i[obl_pkg::WD_OPEN_HI_BIT];
	assign wd_open_period_lo = wd_byte_i[obl_pkg::WD_OPEN_LO_BIT];

	assign wd_interval_irq_use_o = wd_byte_i[obl_pkg::WD_IRQ_BIT];
	assign wd_count_enable_o = wd_byte_i[obl_pkg::WD_ENABLE_BIT];
	assign wd_run_in_standby_o = wd_byte_i[obl_pkg::WD_STANDBY_BIT];
	assign wd_overflow_sel_o = wd_byte_i[obl_pkg::WD_OVF_MSB:obl_pkg::WD_OVF_LSB];
	assign window_prohibited_o = !wd_open_period_hi && !wd_open_period_lo;

	always_comb begin
		if (!wd_run_in_standby_o) begin
			wd_window_o = obl_pkg::OBL_WIN_100;
		end else begin
			wd_window_o = obl_pkg::obl_window_t'({wd_open_period_hi, wd_open_period_lo});
		end
	end

	assign vd_mode_o = obl_pkg::obl_vd_mode_t'(vd_byte_i[obl_pkg::VD_MODE_MSB:obl_pkg::VD_MODE_LSB]);
	assign detect_level_upper_o = vd_byte_i[obl_pkg::VD_UPPER_MSB:obl_pkg::VD_UPPER_LSB];
	assign detect_level_lower_o = vd_byte_i[obl_pkg::VD_LEVEL_MSB:obl_pkg::VD_LEVEL_LSB];
	assign detect_level_single_o = {detect_level_upper_o, detect_level_lower_o};
	assign fixed_bit_bad_o = !vd_byte_i[obl_pkg::VD_FIXED_BIT];

	assign high_speed_main_o = fc_byte_i[obl_pkg::FC_SPEED_BIT];
	assign hoco_freq_o = obl_pkg::obl_hoco_t'(fc_byte_i[obl_pkg::FC_FREQ_MSB:obl_pkg::FC_FREQ_LSB]);

	assign on_chip_debug_enable_o = dbg_byte_i[obl_pkg::DBG_ENABLE_BIT];
	assign keep_flash_on_auth_fail_o = dbg_byte_i[obl_pkg::DBG_KEEP_BIT];
endmodule

// file: obl_loader.sv
// option byte loader: reads the option area at reset and applies it
//
// Functional notes
// - option area is four consecutive flash bytes from the base address
// - first three are user bytes, fourth is the debug byte
// - bytes are read automatically after every reset before operation
// - with boot swap active all four bytes come from the alternate block
// - first byte sets watchdog enable, standby, overflow, window, interval irq
// - second byte selects one of four voltage-detector modes
// - second byte sets the upper, lower and single detection levels
// - third byte selects low-speed or high-speed main flash mode
// - third byte selects one of four oscillator frequencies, 3 to 24 MHz
// - debug byte enables or disables on-chip debug
// - debug byte decides erase or keep on security id failure
// - window code 01 is 50%, 10 is 75%, 11 is 100%, 00 prohibited
// - window fully open whenever standby counting is disabled
// - watchdog counts right after reset only when enable bit is one
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
module obl_loader #(
	parameter int NUM_BYTES = obl_pkg::NUM_BYTES
) (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic ce_i,
	input wire logic boot_swap_i,
	output logic flash_req_o,
	output logic [obl_pkg::ADDR_W-1:0] flash_addr_o,
	input wire logic flash_ack_i,
	input wire logic [obl_pkg::DATA_W-1:0] flash_rdata_i,
	input wire logic [obl_pkg::REG_ADDR_W-1:0] reg_addr_i,
	input wire logic [obl_pkg::DATA_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [obl_pkg::DATA_W-1:0] reg_rdata_o,
	output logic units_reset_o,
	output logic load_done_o,
	output logic wd_interval_irq_use_o,
	output logic wd_count_enable_o,
	output logic wd_counter_run_o,
	output logic wd_run_in_standby_o,
	output logic [2:0] wd_overflow_sel_o,
	output obl_pkg::obl_window_t wd_window_o,
	output obl_pkg::obl_vd_mode_t vd_mode_o,
	output logic [2:0] detect_level_upper_o,
	output logic [1:0] detect_level_lower_o,
	output logic [4:0] detect_level_single_o,
	output logic high_speed_main_o,
	output obl_pkg::obl_hoco_t hoco_freq_o,
	output logic on_chip_debug_enable_o,
	output logic keep_flash_on_auth_fail_o
);
	typedef enum logic [1:0] {
		OBL_ST_START,
		OBL_ST_READ,
		OBL_ST_DONE
	} obl_state_t;

	if (NUM_BYTES != obl_pkg::NUM_BYTES) begin : g_bad_num_bytes
		$error("obl_loader: the option area holds exactly four bytes");
	end

	obl_state_t state_r;
	obl_state_t state_nxt;
	logic [obl_pkg::IDX_W-1:0] idx_r;
	logic swap_r;
	logic [obl_pkg::DATA_W-1:0] opt_r [NUM_BYTES];
	logic [obl_pkg::DATA_W-1:0] reg_rdata_r;
	logic reload_req;
	logic last_ack;
	logic cfg_load;

	// decoded fields of the latched bytes
	logic dec_irq_use;
	logic dec_count_enable;
	logic dec_standby;
	logic [2:0] dec_overflow;
	obl_pkg::obl_window_t dec_window;
	logic dec_window_bad;
	obl_pkg::obl_vd_mode_t dec_vd_mode;
	logic [2:0] dec_upper;
	logic [1:0] dec_lower;
	logic [4:0] dec_single;
	logic dec_fixed_bad;
	logic dec_hs;
	obl_pkg::obl_hoco_t dec_hoco;
	logic dec_ocd;
	logic dec_keep;

	assign reload_req = reg_wr_i && (reg_addr_i == obl_pkg::OFS_LOADER_CONTROL)
		&& reg_wdata_i[obl_pkg::CTRL_RELOAD_BIT];
	assign last_ack = (state_r == OBL_ST_READ) && flash_ack_i && (idx_r == obl_pkg::IDX_LAST);
	assign cfg_load = ce_i && (state_r == OBL_ST_DONE);

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			OBL_ST_START: begin
				state_nxt = OBL_ST_READ;
			end
			OBL_ST_READ: begin
				if (last_ack) begin
					state_nxt = OBL_ST_DONE;
				end
			end
			OBL_ST_DONE: begin
				if (reload_req) begin
					state_nxt = OBL_ST_START;
				end
			end
		endcase
	end

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			state_r <= OBL_ST_START;
		end else if (ce_i) begin
			state_r <= state_nxt;
		end
	end

	// byte index walks the four consecutive locations
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			idx_r <= obl_pkg::IDX_WATCHDOG;
		end else if (ce_i) begin
			if (state_r == OBL_ST_START) begin
				idx_r <= obl_pkg::IDX_WATCHDOG;
			end else if (state_r == OBL_ST_READ && flash_ack_i) begin
				idx_r <= idx_r + 2'h1;
			end
		end
	end

	// copy selection caught once per load
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			swap_r <= 1'b0;
		end else if (ce_i && state_r == OBL_ST_START) begin
			swap_r <= boot_swap_i;
		end
	end

	// read request toward the flash array
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			flash_addr_o <= obl_pkg::PRIMARY_BASE;
		end else if (ce_i) begin
			if (state_r == OBL_ST_START) begin
				flash_addr_o <= boot_swap_i ? obl_pkg::SWAP_BASE : obl_pkg::PRIMARY_BASE;
			end else if (state_r == OBL_ST_READ && flash_ack_i) begin
				flash_addr_o <= flash_addr_o + 20'h00001;
			end
		end
	end

	assign flash_req_o = (state_r == OBL_ST_READ);

	// latched option bytes
	generate
		for (genvar g = 0; g < NUM_BYTES; g++) begin : g_opt
			always_ff @(posedge clock_i or posedge reset_i) begin
				if (reset_i) begin
					opt_r[g] <= obl_pkg::READ_ZERO;
				end else if (ce_i && state_r == OBL_ST_READ && flash_ack_i
					&& idx_r == obl_pkg::IDX_W'(g)) begin
					opt_r[g] <= flash_rdata_i;
				end
			end
		end
	endgenerate

	obl_decode u_decode (
		.wd_byte_i(opt_r[obl_pkg::IDX_WATCHDOG]),
		.vd_byte_i(opt_r[obl_pkg::IDX_VOLTAGE]),
		.fc_byte_i(opt_r[obl_pkg::IDX_FLASH_CLOCK]),
		.dbg_byte_i(opt_r[obl_pkg::IDX_DEBUG]),
		.wd_interval_irq_use_o(dec_irq_use),
		.wd_count_enable_o(dec_count_enable),
		.wd_run_in_standby_o(dec_standby),
		.wd_overflow_sel_o(dec_overflow),
		.wd_window_o(dec_window),
		.window_prohibited_o(dec_window_bad),
		.vd_mode_o(dec_vd_mode),
		.detect_level_upper_o(dec_upper),
		.detect_level_lower_o(dec_lower),
		.detect_level_single_o(dec_single),
		.fixed_bit_bad_o(dec_fixed_bad),
		.high_speed_main_o(dec_hs),
		.hoco_freq_o(dec_hoco),
		.on_chip_debug_enable_o(dec_ocd),
		.keep_flash_on_auth_fail_o(dec_keep)
	);

	// configuration outputs update only when a full set is latched
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			wd_interval_irq_use_o <= 1'b0;
		end else if (cfg_load) begin
			wd_interval_irq_use_o <= dec_irq_use;
		end
	end

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			wd_count_enable_o <= 1'b0;
		end else if (cfg_load) begin
			wd_count_enable_o <= dec_count_enable;
		end
	end

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			wd_run_in_standby_o <= 1'b0;
		end else if (cfg_load) begin
			wd_run_in_standby_o <= dec_standby;
		end
	end

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			wd_overflow_sel_o <= 3'h0;
		end else if (cfg_load) begin
			wd_overflow_sel_o <= dec_overflow;
		end
	end

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			wd_window_o <= obl_pkg::OBL_WIN_100;
		end else if (cfg_load) begin
			wd_window_o <= dec_window;
		end
	end

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			vd_mode_o <= obl_pkg::OBL_VD_OFF_EXT_RESET;
		end else if (cfg_load) begin
			vd_mode_o <= dec_vd_mode;
		end
	end

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			detect_level_upper_o <= 3'h0;
		end else if (cfg_load) begin
			detect_level_upper_o <= dec_upper;
		end
	end

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			detect_level_lower_o <= 2'h0;
		end else if (cfg_load) begin
			detect_level_lower_o <= dec_lower;
		end
	end

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			detect_level_single_o <= 5'h00;
		end else if (cfg_load) begin
			detect_level_single_o <= dec_single;
		end
	end

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			high_speed_main_o <= 1'b0;
		end else if (cfg_load) begin
			high_speed_main_o <= dec_hs;
		end
	end

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			hoco_freq_o <= obl_pkg::OBL_HOCO_3MHZ;
		end else if (cfg_load) begin
			hoco_freq_o <= dec_hoco;
		end
	end

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			on_chip_debug_enable_o <= 1'b0;
		end else if (cfg_load) begin
			on_chip_debug_enable_o <= dec_ocd;
		end
	end

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			keep_flash_on_auth_fail_o <= 1'b0;
		end else if (cfg_load) begin
			keep_flash_on_auth_fail_o <= dec_keep;
		end
	end

	// done and unit reset switch at the edge that first loads the config
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			load_done_o <= 1'b0;
			units_reset_o <= 1'b1;
		end else if (ce_i) begin
			load_done_o <= (state_r == OBL_ST_DONE) && !reload_req;
			units_reset_o <= (state_r != OBL_ST_DONE) || reload_req;
		end
	end

	// watchdog starts one cycle after release only when its enable option is set
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			wd_counter_run_o <= 1'b0;
		end else if (ce_i) begin
			wd_counter_run_o <= load_done_o && wd_count_enable_o;
		end
	end

	// register readback, data in the cycle after the strobe
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			reg_rdata_r <= obl_pkg::READ_ZERO;
		end else if (ce_i) begin
			reg_rdata_r <= obl_pkg::READ_ZERO;
			if (reg_rd_i) begin
				unique case (reg_addr_i)
					obl_pkg::OFS_WATCHDOG_OPTION_BYTE: begin
						reg_rdata_r <= opt_r[obl_pkg::IDX_WATCHDOG];
					end
					obl_pkg::OFS_VOLTAGE_DETECT_OPTION_BYTE: begin
						reg_rdata_r <= opt_r[obl_pkg::IDX_VOLTAGE];
					end
					obl_pkg::OFS_FLASH_CLOCK_OPTION_BYTE: begin
						reg_rdata_r <= opt_r[obl_pkg::IDX_FLASH_CLOCK];
					end
					obl_pkg::OFS_DEBUG_OPTION_BYTE: begin
						reg_rdata_r <= opt_r[obl_pkg::IDX_DEBUG];
					end
					obl_pkg::OFS_LOADER_STATUS: begin
						reg_rdata_r[obl_pkg::STAT_DONE_BIT] <= load_done_o;
						reg_rdata_r[obl_pkg::STAT_SWAP_BIT] <= swap_r;
						reg_rdata_r[obl_pkg::STAT_WINDOW_ERR_BIT] <= dec_window_bad && load_done_o;
						reg_rdata_r[obl_pkg::STAT_FIXED_ERR_BIT] <= dec_fixed_bad && load_done_o;
					end
					default: begin
						reg_rdata_r <= obl_pkg::READ_ZERO;
					end
				endcase
			end
		end
	end

	assign reg_rdata_o = reg_rdata_r;
endmodule

// file: obl_loader_assertions.sv
// concurrent checks on the ports of the option byte loader
`timescale 1ns/1ps
module obl_loader_assertions #(
	parameter int NUM_BYTES = 4
) (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic ce_i,
	input wire logic flash_req_o,
	input wire logic [obl_pkg::ADDR_W-1:0] flash_addr_o,
	input wire logic flash_ack_i,
	input wire logic units_reset_o,
	input wire logic load_done_o,
	input wire logic wd_count_enable_o,
	input wire logic wd_counter_run_o,
	input wire logic wd_run_in_standby_o,
	input wire obl_pkg::obl_window_t wd_window_o,
	input wire logic [2:0] detect_level_upper_o,
	input wire logic [1:0] detect_level_lower_o,
	input wire logic [4:0] detect_level_single_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (reset_i);
	chk_addr_hold: assert property (flash_req_o && !flash_ack_i |=> flash_req_o && $stable(flash_addr_o))
		else $error("flash request moved before ack");
	chk_addr_step: assert property (ce_i && flash_req_o && flash_ack_i && flash_addr_o[1:0] != 2'h3
		|=> flash_addr_o == $past(flash_addr_o) + 20'h1)
		else $error("flash address did not advance by one");
	chk_read_held: assert property (flash_req_o |-> units_reset_o && !load_done_o)
		else $error("units released while loading");
	chk_release_time: assert property (ce_i && flash_req_o && flash_ack_i && flash_addr_o[1:0] == 2'h3
		|=> units_reset_o ##[1:2] (!units_reset_o && load_done_o))
		else $error("units not released after last byte");
	chk_window_force: assert property (!wd_run_in_standby_o |-> wd_window_o == obl_pkg::OBL_WIN_100)
		else $error("window not fully open without standby counting");
	chk_counter_run: assert property (ce_i && load_done_o && wd_count_enable_o |=> wd_counter_run_o)
		else $error("watchdog counter not started");
	chk_counter_stop: assert property (ce_i && !(load_done_o && wd_count_enable_o) |=> !wd_counter_run_o)
		else $error("watchdog counter ran while disabled");
	chk_single_level: assert property (detect_level_single_o == {detect_level_upper_o, detect_level_lower_o})
		else $error("single level mismatch");
	cov_swap: cover property (flash_req_o && flash_ack_i && flash_addr_o == obl_pkg::SWAP_BASE);
	cov_b2b: cover property (flash_req_o && flash_ack_i ##1 flash_req_o && flash_ack_i);
	cov_reload: cover property ($rose(units_reset_o));
endmodule

bind obl_loader obl_loader_assertions #(.NUM_BYTES(NUM_BYTES)) u_chk (.clock_i(clock_i),
	.reset_i(reset_i), .ce_i(ce_i), .flash_req_o(flash_req_o), .flash_addr_o(flash_addr_o),
	.flash_ack_i(flash_ack_i), .units_reset_o(units_reset_o), .load_done_o(load_done_o),
	.wd_count_enable_o(wd_count_enable_o), .wd_counter_run_o(wd_counter_run_o),
	.wd_run_in_standby_o(wd_run_in_standby_o), .wd_window_o(wd_window_o),
	.detect_level_upper_o(detect_level_upper_o), .detect_level_lower_o(detect_level_lower_o),
	.detect_level_single_o(detect_level_single_o));

// file: obl_flash_model.sv
// flash array model holding primary and alternate option bytes
`timescale 1ns/1ps
module obl_flash_model (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic req_i,
	input wire logic [19:0] addr_i,
	input wire logic [3:0] delay_i,
	output logic ack_o,
	output logic [7:0] rdata_o
);
	logic [7:0] mem [8];
	logic [7:0] last_r;
	logic [3:0] wait_r;
	logic hit;
	assign hit = addr_i[19:2] == 18'h00030 || addr_i[19:2] == 18'h00430;
	assign ack_o = req_i && wait_r >= delay_i;
	// off-hit or idle data is the inverse of last_r, which idle cycles toggle, so idle data can repeat the last byte
	assign rdata_o = (ack_o && hit) ? mem[{addr_i[12], addr_i[1:0]}] : ~last_r;
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			wait_r <= 4'h0;
			last_r <= 8'h00;
		end else if (ack_o) begin
			wait_r <= 4'h0;
			last_r <= rdata_o;
		end else if (req_i) begin
			wait_r <= wait_r + 4'h1;
		end else begin
			last_r <= ~last_r;
		end
	end
endmodule

// file: obl_loader_tb.sv
// self-checking bench of the option byte loader
`timescale 1ns/1ps
module obl_loader_tb;
	// bytes b0 b1 b2 b3 per load
	localparam logic [31:0] CASES [5] = '{32'hF17E8381, 32'hA5110100, 32'h1E030280,
		32'h09108001, 32'hCFF28180};
	localparam logic [4:0] SWAPS = 5'b00010;
	localparam logic [3:0] DELAYS [5] = '{4'h0, 4'h2, 4'h1, 4'h3, 4'h0};
	logic clock_i = 1'b0;
	logic reset_i = 1'b1;
	logic ce_i = 1'b1;
	logic boot_swap_i = 1'b0;
	logic [7:0] reg_addr_i = 8'h00;
	logic [7:0] reg_wdata_i = 8'h00;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [3:0] flash_delay = 4'h0;
	logic flash_req_o, flash_ack_i, units_reset_o, load_done_o;
	logic [19:0] flash_addr_o;
	logic [7:0] flash_rdata_i, reg_rdata_o, rd;
	logic wd_interval_irq_use_o, wd_count_enable_o, wd_counter_run_o, wd_run_in_standby_o;
	logic [2:0] wd_overflow_sel_o, detect_level_upper_o;
	logic [1:0] detect_level_lower_o;
	logic [4:0] detect_level_single_o;
	logic high_speed_main_o, on_chip_debug_enable_o, keep_flash_on_auth_fail_o;
	obl_pkg::obl_window_t wd_window_o;
	obl_pkg::obl_vd_mode_t vd_mode_o;
	obl_pkg::obl_hoco_t hoco_freq_o;
	int fails = 0;
	int compares = 0;
	logic [19:0] addr_log [$];

	obl_loader dut (.clock_i(clock_i), .reset_i(reset_i), .ce_i(ce_i), .boot_swap_i(boot_swap_i),
		.flash_req_o(flash_req_o), .flash_addr_o(flash_addr_o), .flash_ack_i(flash_ack_i),
		.flash_rdata_i(flash_rdata_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.units_reset_o(units_reset_o), .load_done_o(load_done_o),
		.wd_interval_irq_use_o(wd_interval_irq_use_o), .wd_count_enable_o(wd_count_enable_o),
		.wd_counter_run_o(wd_counter_run_o), .wd_run_in_standby_o(wd_run_in_standby_o),
		.wd_overflow_sel_o(wd_overflow_sel_o), .wd_window_o(wd_window_o), .vd_mode_o(vd_mode_o),
		.detect_level_upper_o(detect_level_upper_o), .detect_level_lower_o(detect_level_lower_o),
		.detect_level_single_o(detect_level_single_o), .high_speed_main_o(high_speed_main_o),
		.hoco_freq_o(hoco_freq_o), .on_chip_debug_enable_o(on_chip_debug_enable_o),
		.keep_flash_on_auth_fail_o(keep_flash_on_auth_fail_o));
	obl_flash_model flash (.clock_i(clock_i), .reset_i(reset_i), .req_i(flash_req_o),
		.addr_i(flash_addr_o), .delay_i(flash_delay), .ack_o(flash_ack_i), .rdata_o(flash_rdata_i));

	initial begin
		forever #2.5 clock_i = ~clock_i;
	end
	always @(posedge clock_i) begin
		if (flash_req_o === 1'b1 && flash_ack_i === 1'b1)
			addr_log.push_back(flash_addr_o);
	end

	task check(input string what, input logic [19:0] seen, input logic [19:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task wrap_up;
		if (fails == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task pulse_reset;
		@(posedge clock_i);
		reset_i <= 1'b1;
		repeat (2) @(posedge clock_i);
		addr_log.delete();
		reset_i <= 1'b0;
	endtask
	task wait_done;
		for (int n = 0; n < 100; n++) begin
			@(posedge clock_i);
			#1;
			if (load_done_o === 1'b1)
				break;
		end
		check("done", load_done_o, 1'b1);
	endtask
	task reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clock_i);
		reg_wr_i <= 1'b0;
	endtask
	task reg_rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clock_i);
		reg_rd_i <= 1'b0;
		#1 d = reg_rdata_o;
	endtask
	task check_cfg(input logic [31:0] c);
		logic [7:0] b0, b1;
		b0 = c[31:24];
		b1 = c[23:16];
		check("irq", wd_interval_irq_use_o, b0[7]);
		check("window", wd_window_o, b0[0] ? b0[6:5] : 2'h3);
		check("enable", wd_count_enable_o, b0[4]);
		check("overflow", wd_overflow_sel_o, b0[3:1]);
		check("standby", wd_run_in_standby_o, b0[0]);
		check("run", wd_counter_run_o, b0[4]);
		check("vd mode", vd_mode_o, b1[1:0]);
		check("upper", detect_level_upper_o, b1[7:5]);
		check("lower", detect_level_lower_o, b1[3:2]);
		check("single", detect_level_single_o, {b1[7:5], b1[3:2]});
		check("speed", high_speed_main_o, c[15]);
		check("hoco", hoco_freq_o, c[9:8]);
		check("debug", on_chip_debug_enable_o, c[7]);
		check("keep", keep_flash_on_auth_fail_o, c[0]);
		for (int k = 0; k < 4; k++) begin
			reg_rd(obl_pkg::OFS_WATCHDOG_OPTION_BYTE + 8'(k), rd);
			check("option reg", rd, c[31-8*k -: 8]);
		end
	endtask
	// both copies alike; the source shows in the fetch addresses
	task t_load(input int i, input bit mid);
		for (int k = 0; k < 4; k++) begin
			flash.mem[k] = CASES[i][31-8*k -: 8];
			flash.mem[4+k] = CASES[i][31-8*k -: 8];
		end
		boot_swap_i <= SWAPS[i];
		flash_delay <= DELAYS[i];
		pulse_reset();
		if (mid) begin
			repeat (6) @(posedge clock_i);
			pulse_reset();
		end
		wait_done();
		check("fetches", addr_log.size(), 20'h4);
		for (int k = 0; k < 4; k++)
			check("addr", addr_log[k], (SWAPS[i] ? 20'h010C0 : 20'h000C0) + 20'(k));
		@(posedge clock_i);
		#1 check_cfg(CASES[i]);
		reg_rd(obl_pkg::OFS_LOADER_STATUS, rd);
		check("status", rd, {4'h0, ~CASES[i][20], ~|CASES[i][30:29], SWAPS[i], 1'b1});
	endtask
	task t_regs;
		reg_rd(8'hD0, rd);
		check("unmapped", rd, 8'h00);
		reg_wr(obl_pkg::OFS_WATCHDOG_OPTION_BYTE, 8'h5A);
		reg_rd(obl_pkg::OFS_WATCHDOG_OPTION_BYTE, rd);
		check("read only", rd, CASES[1][31:24]);
	endtask
	task t_reload;
		for (int k = 0; k < 4; k++)
			flash.mem[k] = CASES[0][31-8*k -: 8];
		boot_swap_i <= 1'b0;
		flash_delay <= 4'h1;
		reg_wr(obl_pkg::OFS_LOADER_CONTROL, 8'h01);
		#1 check("held", units_reset_o, 1'b1);
		check("kept", wd_overflow_sel_o, CASES[1][27:25]);
		@(posedge clock_i);
		ce_i <= 1'b0;
		repeat (4) @(posedge clock_i);
		#1 check("frozen addr", flash_addr_o, obl_pkg::PRIMARY_BASE);
		check("frozen hold", units_reset_o, 1'b1);
		ce_i <= 1'b1;
		wait_done();
		@(posedge clock_i);
		#1 check_cfg(CASES[0]);
	endtask

	initial begin
		repeat (2) @(posedge clock_i);
		#1 check("rst units", units_reset_o, 1'b1);
		check("rst done", load_done_o, 1'b0);
		check("rst req", flash_req_o, 1'b0);
		for (int i = 0; i < 5; i++)
			t_load(i, 1'b0);
		t_load(1, 1'b1);
		t_regs();
		t_reload();
		wrap_up();
	end
	initial begin
		#20000;
		fails++;
		wrap_up();
	end
endmodule
